// ---- include/flash_cmd_pkg.sv ----
// Package: register map, command codes, sector layout and timing for the flash command sequencer
package flash_cmd_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_SECTOR_WE = 8'h04;
  localparam logic [7:0] ADDR_COMMAND_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CMD_ADDR = 8'h0C;
  localparam logic [7:0] ADDR_CMD_DATA = 8'h10;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_GLOBAL_WE_BIT = 0;
  localparam int CTRL_MCLK_SLOW_BIT = 1;
  localparam int STAT_SUSPENDED_BIT = 3;
  localparam int STAT_ERASE_BUSY_BIT = 2;
  localparam int STAT_PROGRAM_BUSY_BIT = 1;
  localparam int STAT_HANG_BIT = 0;
  localparam int NUM_SECTORS = 3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [1:0] CONTROL_RESET = 2'h0;
  localparam logic [2:0] SECTOR_WE_RESET = 3'h0;
  localparam logic [3:0] STATUS_RESET = 4'h0;

  // ****************************************
  // Command codes and offsets
  // ****************************************
  localparam logic [11:0] OFS_FIRST = 12'hAAA;
  localparam logic [11:0] OFS_SECOND = 12'h554;
  localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_RESET = 8'hF0;
  localparam logic [7:0] CODE_PROGRAM = 8'hA0;
  localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CODE_SUSPEND = 8'hB0;
  localparam logic [3:0] NIB_RESET_HI = 4'hF;
  localparam logic [7:0] BYTE_RESET_FF = 8'hFF;
  localparam logic [7:0] BYTE_RESET_FE = 8'hFE;

  // ****************************************
  // Sector boundaries on the CPU map
  // ****************************************
  localparam logic [15:0] SECTOR0_BASE = 16'hB000;
  localparam logic [15:0] SECTOR1_BASE = 16'hB800;
  localparam logic [15:0] SECTOR2_BASE = 16'hC000;
  localparam logic [15:0] SECTOR1_HI_BASE = 16'hF800;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int STATUS_DELAY_CYCLES = 2;
  localparam int PROGRAM_TIME_NS = 160;
  localparam int ERASE_TIME_NS = 2000;
  localparam int PROGRAM_CYCLES = (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;

  // Sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_C1, SEQ_C2, SEQ_PROG_DATA, SEQ_E3, SEQ_E4, SEQ_E5, SEQ_RESET_READ
  } seq_state_t;

endpackage : flash_cmd_pkg

// ---- core/flash_command_sequencer_status.sv ----
// Flash command sequencer with write-protect gating and command status register on APB
`timescale 1ns/10ps

module flash_command_sequencer_status (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic flash_program_strobe,
  output logic [15:0] program_address,
  output logic [7:0] program_value,
  output logic [flash_cmd_pkg::NUM_SECTORS-1:0] sector_erase_active
);
  import flash_cmd_pkg::*;

  // ****************************************
  // APB decode
  // ****************************************
  // Address decode of the five word registers
  logic access_w;
  logic wr_w;
  logic hit_ctrl_w;
  logic hit_swe_w;
  logic hit_stat_w;
  logic hit_addr_w;
  logic hit_data_w;
  logic mapped_w;
  // Ready answers the setup cycle, so the access phase is one cycle long;
  // qualifying by ready keeps a stretched access from applying a write twice
  assign access_w = psel & penable & pready;
  assign wr_w = access_w & pwrite;
  assign hit_ctrl_w = (paddr == ADDR_CONTROL);
  assign hit_swe_w = (paddr == ADDR_SECTOR_WE);
  assign hit_stat_w = (paddr == ADDR_COMMAND_STATUS);
  assign hit_addr_w = (paddr == ADDR_CMD_ADDR);
  assign hit_data_w = (paddr == ADDR_CMD_DATA);
  assign mapped_w = hit_ctrl_w | hit_swe_w | hit_stat_w | hit_addr_w | hit_data_w;

  // ****************************************
  // Registers
  // ****************************************
  // Register state and the timer shared by program and erase
  logic [1:0] control_reg;
  logic [2:0] sector_we_reg;
  logic [2:0] sector_locked_reg;
  logic [15:0] cmd_addr_reg;
  seq_state_t state_reg;
  seq_state_t state_next;
  logic erase_busy_reg;
  logic suspended_reg;
  logic program_busy_reg;
  logic hang_reg;
  logic chip_erase_reg;
  logic [2:0] erase_sectors_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic global_write_enable;
  logic mclk_slow;
  // Control fields by name
  assign global_write_enable = control_reg[CTRL_GLOBAL_WE_BIT];
  assign mclk_slow = control_reg[CTRL_MCLK_SLOW_BIT];

  // Control register write: bit zero gates all flash writes, bit one flags a
  // machine clock too slow for the program-busy flag to be meaningful
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= CONTROL_RESET;
    end else if (wr_w && hit_ctrl_w) begin
      control_reg <= pwdata[1:0];
    end
  end

  // Sector enables: a zero written once locks that sector out until reset,
  // so a stray clear cannot be undone by software, only by a system reset
  logic [2:0] swe_next;
  assign swe_next = pwdata[2:0] & ~(sector_locked_reg | (sector_we_reg & ~pwdata[2:0]));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sector_we_reg <= SECTOR_WE_RESET;
      sector_locked_reg <= SECTOR_WE_RESET;
    end else if (wr_w && hit_swe_w) begin
      sector_we_reg <= swe_next;
      sector_locked_reg <= sector_locked_reg | ~pwdata[2:0];
    end
  end

  // Address latch for the next command cycle; software writes it before each
  // data byte, as the latch holds its value and a later command would reuse a stale address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_addr_reg <= 16'h0000;
    end else if (wr_w && hit_addr_w) begin
      cmd_addr_reg <= pwdata[15:0];
    end
  end

  // ****************************************
  // Command cycle decode
  // ****************************************
  // A write to the data register is one flash bus write cycle at cmd_addr_reg;
  // the low byte lane carries the data and the upper lanes are ignored
  logic cyc_w;
  logic [7:0] cd_w;
  logic [11:0] ofs_w;
  logic [3:0] nib_w;
  logic [3:0] u_reg;
  logic is_aa_w;
  logic is_55_w;
  logic is_3rd_w;
  logic nib_ok_w;
  logic single_reset_w;
  logic [2:0] sec_hit_w;
  logic sec_ok_w;
  logic all_ok_w;

  assign cyc_w = wr_w & hit_data_w;
  assign cd_w = pwdata[7:0];
  assign ofs_w = cmd_addr_reg[11:0];
  assign nib_w = cmd_addr_reg[15:12];
  assign nib_ok_w = (nib_w == u_reg);
  assign is_aa_w = (ofs_w == OFS_FIRST) && (cd_w == CODE_UNLOCK1);
  assign is_55_w = (ofs_w == OFS_SECOND) && (cd_w == CODE_UNLOCK2);
  assign is_3rd_w = (ofs_w == OFS_FIRST);
  assign single_reset_w = (cd_w == CODE_RESET) && ((cmd_addr_reg[15:8] == BYTE_RESET_FF) ||
                          (cmd_addr_reg[15:8] == BYTE_RESET_FE));
  // Sector membership of the target address; the top of the map belongs to
  // sector one, so sector two stops short of it
  assign sec_hit_w[0] = (cmd_addr_reg >= SECTOR0_BASE) && (cmd_addr_reg < SECTOR1_BASE);
  assign sec_hit_w[1] = ((cmd_addr_reg >= SECTOR1_BASE) && (cmd_addr_reg < SECTOR2_BASE)) ||
                        (cmd_addr_reg >= SECTOR1_HI_BASE);
  assign sec_hit_w[2] = (cmd_addr_reg >= SECTOR2_BASE) && (cmd_addr_reg < SECTOR1_HI_BASE);
  // Global enable gates every sector enable
  assign sec_ok_w = global_write_enable && ((sec_hit_w & sector_we_reg) != 3'h0);
  assign all_ok_w = global_write_enable && (sector_we_reg == {NUM_SECTORS{1'b1}});

  // Command strobes; a new sequence may not open while an operation runs,
  // except that a parked erase leaves room for a programme
  logic busy_w;
  logic suspend_w;
  logic resume_w;
  logic start_prog_w;
  logic start_chip_w;
  logic start_sector_w;
  logic bad_w;
  logic reset_cmd_w;
  assign busy_w = program_busy_reg | (erase_busy_reg & ~suspended_reg) | chip_erase_reg;
  assign suspend_w = cyc_w && erase_busy_reg && !suspended_reg && (cd_w == CODE_SUSPEND) && nib_ok_w;
  assign resume_w = cyc_w && suspended_reg && !program_busy_reg && (state_reg == SEQ_IDLE) &&
                    (cd_w == CODE_SECTOR_ERASE) && nib_ok_w;
  assign reset_cmd_w = cyc_w && (single_reset_w ||
                       ((state_reg == SEQ_C2) && is_3rd_w && nib_ok_w && (cd_w == CODE_RESET)));
  assign start_prog_w = cyc_w && (state_reg == SEQ_PROG_DATA) && (nib_w == u_reg) && sec_ok_w;
  assign start_chip_w = cyc_w && (state_reg == SEQ_E5) && is_3rd_w &&
                        (cd_w == CODE_CHIP_ERASE) && all_ok_w;
  assign start_sector_w = cyc_w && (state_reg == SEQ_E5) && !erase_busy_reg &&
                          (cd_w == CODE_SECTOR_ERASE) && nib_ok_w && sec_ok_w;
  // A full command whose last cycle is refused by write protection is still a
  // recognised command: it is dropped quietly and does not count as a malfunction
  logic gated_w;
  assign gated_w = cyc_w && (((state_reg == SEQ_PROG_DATA) && nib_ok_w) ||
                   ((state_reg == SEQ_E5) && is_3rd_w && (cd_w == CODE_CHIP_ERASE)) ||
                   ((state_reg == SEQ_E5) && (cd_w == CODE_SECTOR_ERASE) && nib_ok_w));
  // A cycle the sequencer cannot place marks a command input malfunction
  assign bad_w = cyc_w && !reset_cmd_w && !suspend_w && !resume_w && (state_next == SEQ_IDLE) &&
                 !gated_w && !((state_reg == SEQ_IDLE) && is_aa_w);

  // ****************************************
  // Sequencer next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    if (cyc_w) begin
      if (reset_cmd_w) begin
        // A reset command sends the sequencer to idle, or to SEQ_RESET_READ for the three-cycle form
        state_next = (single_reset_w) ? SEQ_IDLE : SEQ_RESET_READ;
      end else begin
        // Any mismatch drops the partial sequence
        state_next = SEQ_IDLE;
        case (state_reg)
          SEQ_IDLE, SEQ_RESET_READ: begin
            if (is_aa_w && !busy_w) begin
              state_next = SEQ_C1;
            end
          end
          SEQ_C1: begin
            if (is_55_w) begin
              state_next = SEQ_C2;
            end
          end
          // Erase setup is refused while an erase is parked
          SEQ_C2: begin
            if (is_3rd_w && cd_w == CODE_PROGRAM && nib_ok_w) begin
              state_next = SEQ_PROG_DATA;
            end else if (is_3rd_w && cd_w == CODE_ERASE_SETUP && !suspended_reg) begin
              state_next = SEQ_E3;
            end
          end
          SEQ_E3: begin
            if (is_aa_w) begin
              state_next = SEQ_E4;
            end
          end
          SEQ_E4: begin
            if (is_55_w) begin
              state_next = SEQ_E5;
            end
          end
          default: begin
            state_next = SEQ_IDLE;
          end
        endcase
      end
    end
  end

  // Sequence state and the upper nibble captured on any AA cycle outside SEQ_C1 and SEQ_E4, so on the first and on an erase's fourth;
  // later U-marked cycles except the 55 unlock cycles, erase setup and chip erase are held against it, so a wandering nibble there aborts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SEQ_IDLE;
      u_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      if (cyc_w && state_reg != SEQ_C1 && state_reg != SEQ_E4 && is_aa_w) begin
        u_reg <= nib_w;
      end
    end
  end

  // ****************************************
  // Operation timers and status flags
  // ****************************************
  // Flags update at the edge after the command cycle, inside the two-clock window.
  // A parked erase freezes its count until a programme, the only operation allowed meanwhile, reloads the shared timer,
  // and the busy flags are cleared only when the shared timer runs out
  logic timer_done_w;
  assign timer_done_w = (timer_reg == {TIMER_W{1'b0}});
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_busy_reg <= 1'b0;
      erase_busy_reg <= 1'b0;
      suspended_reg <= 1'b0;
      chip_erase_reg <= 1'b0;
      erase_sectors_reg <= 3'h0;
      timer_reg <= {TIMER_W{1'b0}};
    end else begin
      if (start_prog_w) begin
        program_busy_reg <= 1'b1;
        timer_reg <= TIMER_W'(PROGRAM_CYCLES);
      end else if (start_chip_w) begin
        chip_erase_reg <= 1'b1;
        timer_reg <= TIMER_W'(ERASE_CYCLES);
      end else if (start_sector_w) begin
        erase_busy_reg <= 1'b1;
        erase_sectors_reg <= sec_hit_w;
        timer_reg <= TIMER_W'(ERASE_CYCLES);
      end else if (suspend_w) begin
        suspended_reg <= 1'b1;
      end else if (resume_w) begin
        suspended_reg <= 1'b0;
      end else if (!timer_done_w && !(erase_busy_reg && suspended_reg && !program_busy_reg)) begin
        timer_reg <= timer_reg - TIMER_W'(1);
      end else if (timer_done_w) begin
        // Finished operation; a programme during suspend returns to the paused erase
        if (program_busy_reg) begin
          program_busy_reg <= 1'b0;
        end else if (!suspended_reg) begin
          erase_busy_reg <= 1'b0;
          chip_erase_reg <= 1'b0;
          erase_sectors_reg <= 3'h0;
        end
      end
    end
  end

  // Hang flag: a malformed cycle sets it, a reset command clears it, and a
  // reset command cycle never counts as malformed, so its clear always lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hang_reg <= 1'b0;
    end else if (bad_w) begin
      hang_reg <= 1'b1;
    end else if (reset_cmd_w) begin
      hang_reg <= 1'b0;
    end
  end

  // ****************************************
  // Status view and APB read data
  // ****************************************
  logic [3:0] status_w;
  logic [31:0] rdata_w;
  assign status_w[STAT_SUSPENDED_BIT] = suspended_reg;
  assign status_w[STAT_ERASE_BUSY_BIT] = erase_busy_reg;
  assign status_w[STAT_PROGRAM_BUSY_BIT] = program_busy_reg & ~mclk_slow;
  assign status_w[STAT_HANG_BIT] = hang_reg;
  // Upper status bits are hard zero; writes to the status word are dropped.
  // The program-busy view is masked while the machine clock is flagged slow
  assign rdata_w = hit_ctrl_w ? {30'h0, control_reg} :
                   hit_swe_w ? {29'h0, sector_we_reg} :
                   hit_stat_w ? {28'h0, status_w} :
                   hit_addr_w ? {16'h0, cmd_addr_reg} : 32'h0;

  // Registered APB answers; ready answers the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & ~mapped_w;
      prdata <= rdata_w;
    end
  end

  // Program strobe and its target; the target holds until the next accepted program
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_program_strobe <= 1'b0;
      program_address <= 16'h0000;
      program_value <= 8'h00;
    end else begin
      flash_program_strobe <= start_prog_w;
      if (start_prog_w) begin
        program_address <= cmd_addr_reg;
        program_value <= cd_w;
      end
    end
  end

  // Sectors under erase: all on chip erase, none while a sector erase is parked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sector_erase_active <= 3'h0;
    end else begin
      sector_erase_active <= chip_erase_reg ? {NUM_SECTORS{1'b1}} :
                             (suspended_reg ? 3'h0 : erase_sectors_reg);
    end
  end

endmodule : flash_command_sequencer_status

// ---- dv/flash_status_monitor.sv ----
// Checker for the flash command sequencer's bus and command outputs
`timescale 1ns/10ps
module flash_status_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic flash_program_strobe,
  input wire logic [flash_cmd_pkg::NUM_SECTORS-1:0] sector_erase_active
);
  import flash_cmd_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Command data write and status read decodes
  wire cmd_wr = psel && penable && pwrite && paddr == ADDR_CMD_DATA;
  wire st_rd = pready && psel && !pwrite && paddr == ADDR_COMMAND_STATUS;
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("ready late");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held");
  a_error_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_status_upper_zero: assert property (st_rd |-> prdata[31:4] == 28'h0)
    else $error("status upper bits set");
  a_strobe_one_cycle: assert property (flash_program_strobe |=> !flash_program_strobe)
    else $error("strobe held");
  a_strobe_has_cause: assert property (flash_program_strobe |-> $past(cmd_wr) || $past(cmd_wr, 2))
    else $error("strobe without data write");
  a_erase_has_cause: assert property (sector_erase_active != 3'h0 && $past(sector_erase_active) == 3'h0 |->
    $past(cmd_wr) || $past(cmd_wr, 2)) else $error("erase without command");
  a_suspend_no_erase: assert property (st_rd && prdata[3] |-> sector_erase_active == 3'h0)
    else $error("erasing while suspended");
endmodule : flash_status_monitor

bind flash_command_sequencer_status flash_status_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .flash_program_strobe(flash_program_strobe), .sector_erase_active(sector_erase_active));

// ---- dv/cpu_bus_master.sv ----
// CPU side model: APB transfers and flash bus write cycles
`timescale 1ns/10ps
module cpu_bus_master (
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  import flash_cmd_pkg::*;
  logic timed_out;
  initial begin
    {psel, penable, pwrite, paddr, pwdata, timed_out} = '0;
  end
  // One transfer; released address and data lines show inverted values, while pwrite keeps its last value
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) timed_out = 1'b1;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask : wr
  // One flash bus write, then two idle clocks before any status read
  task automatic flash_write(input logic [15:0] a, input logic [7:0] d);
    wr(ADDR_CMD_ADDR, {16'h0000, a});
    wr(ADDR_CMD_DATA, {24'h000000, d});
    repeat (2) @(posedge pclk);
  endtask : flash_write
endmodule : cpu_bus_master

// ---- dv/tb_top.sv ----
// Self-checking bench for the flash command sequencer
`timescale 1ns/10ps
module tb_top;
  import flash_cmd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, flash_program_strobe;
  logic [7:0] paddr, program_value, pv;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] program_address, pa;
  logic [NUM_SECTORS-1:0] sector_erase_active;
  logic er;
  integer num_errors = 0, comparisons = 0, strobes = 0;
  // ****************************************
  // Clock, design and CPU model
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Reference model: accepted programmes queue up and each strobe must match the oldest
  logic [23:0] prog_q[$];
  always @(posedge pclk) begin
    if (flash_program_strobe === 1'b1) begin
      strobes <= strobes + 1;
      if (prog_q.size() == 0) chk(32'h1, 32'h0);
      else chk({8'h0, program_address, program_value}, {8'h0, prog_q.pop_front()});
    end
  end
  flash_command_sequencer_status uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_program_strobe(flash_program_strobe), .program_address(program_address),
    .program_value(program_value), .sector_erase_active(sector_erase_active));
  cpu_bus_master m (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // ****************************************
  // Checking and command helpers
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Masked status read; upper bits always compared
  task automatic stat(input logic [3:0] mask, input logic [3:0] exp);
    m.xfer(1'b0, ADDR_COMMAND_STATUS, 32'h0, rd, er);
    chk(rd & {28'hFFFFFFF, mask}, {28'h0, exp & mask});
  endtask : stat
  task automatic cmd3(input logic [3:0] u, input logic [7:0] c);
    m.flash_write({u, OFS_FIRST}, CODE_UNLOCK1);
    m.flash_write({u, OFS_SECOND}, CODE_UNLOCK2);
    m.flash_write({u, OFS_FIRST}, c);
  endtask : cmd3
  task automatic ers(input logic [3:0] u, input logic [15:0] last, input logic [7:0] c);
    cmd3(u, CODE_ERASE_SETUP);
    m.flash_write({u, OFS_FIRST}, CODE_UNLOCK1);
    m.flash_write({u, OFS_SECOND}, CODE_UNLOCK2);
    m.flash_write(last, c);
  endtask : ers
  // Poll until nothing is busy; bounded so a stuck flag ends the run
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      m.xfer(1'b0, ADDR_COMMAND_STATUS, 32'h0, rd, er);
      n++;
    end while ((rd[2:1] !== 2'b00 || sector_erase_active !== 3'h0) && n < 200);
    if (rd[2:1] !== 2'b00 || sector_erase_active !== 3'h0) begin
      num_errors++;
      $display("unexpected at %0t: flash stays busy", $time);
      tally_and_finish();
    end
  endtask : wait_idle
  task automatic tally_and_finish();
    if (m.timed_out) num_errors++;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    void'($urandom(32'hBAA9));
    m.xfer(1'b0, ADDR_COMMAND_STATUS, 32'h0, rd, er);
    chk(rd, 32'h0);
    m.xfer(1'b0, 8'hFC, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1);
    $display("test reset done");
    m.wr(ADDR_CONTROL, 32'h1);
    m.wr(ADDR_SECTOR_WE, 32'h7);
    m.wr(ADDR_CONTROL, 32'h0);
    cmd3(4'hB, CODE_PROGRAM);
    m.flash_write(16'hB010, 8'h5A);
    stat(4'hF, 4'h0);
    chk(strobes, 0);
    $display("test write gate done");
    m.wr(ADDR_CONTROL, 32'h1);
    pa = {5'b10110, 11'($urandom)};
    pv = 8'($urandom);
    cmd3(pa[15:12], CODE_PROGRAM);
    prog_q.push_back({pa, pv});
    m.flash_write(pa, pv);
    stat(4'hF, 4'h2);
    chk({8'h0, program_address, program_value}, {8'h0, pa, pv});
    chk(strobes, 1);
    wait_idle();
    stat(4'hF, 4'h0);
    m.wr(ADDR_CONTROL, 32'h3);
    cmd3(pa[15:12], CODE_PROGRAM);
    prog_q.push_back({pa, ~pv});
    m.flash_write(pa, ~pv);
    stat(4'h2, 4'h0);
    m.wr(ADDR_CONTROL, 32'h1);
    wait_idle();
    $display("test program done");
    ers(4'hC, 16'hC123, CODE_SECTOR_ERASE);
    stat(4'hF, 4'h4);
    chk({29'h0, sector_erase_active}, 32'h4);
    m.flash_write(16'hC000, CODE_SUSPEND);
    stat(4'h8, 4'h8);
    chk({29'h0, sector_erase_active}, 32'h0);
    m.flash_write(16'hCFFF, CODE_SECTOR_ERASE);
    stat(4'hF, 4'h4);
    wait_idle();
    stat(4'hF, 4'h0);
    ers(4'h3, {4'h3, OFS_FIRST}, CODE_CHIP_ERASE);
    chk({29'h0, sector_erase_active}, 32'h7);
    wait_idle();
    $display("test erase done");
    // Broken sequence, then each form of the reset command
    for (int i = 0; i < 3; i++) begin
      m.flash_write({4'hB, OFS_FIRST}, CODE_UNLOCK1);
      m.flash_write(16'hB000, 8'h12);
      stat(4'h1, 4'h1);
      if (i < 2)
        m.flash_write(i == 0 ? 16'hFF00 : 16'hFE42, CODE_RESET);
      else
        cmd3(4'hB, CODE_RESET);
      stat(4'h1, 4'h0);
    end
    $display("test hang done");
    m.wr(ADDR_SECTOR_WE, 32'h3);
    m.wr(ADDR_SECTOR_WE, 32'h7);
    m.xfer(1'b0, ADDR_SECTOR_WE, 32'h0, rd, er);
    chk(rd & 32'h7, 32'h3);
    ers(4'h3, {4'h3, OFS_FIRST}, CODE_CHIP_ERASE);
    chk({29'h0, sector_erase_active}, 32'h0);
    stat(4'hF, 4'h0);
    $display("test lock done");
    // System reset in mid-run lifts every sector lock
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    m.xfer(1'b0, ADDR_COMMAND_STATUS, 32'h0, rd, er);
    chk(rd, 32'h0);
    m.wr(ADDR_CONTROL, 32'h1);
    m.wr(ADDR_SECTOR_WE, 32'h7);
    m.xfer(1'b0, ADDR_SECTOR_WE, 32'h0, rd, er);
    chk(rd & 32'h7, 32'h7);
    chk(prog_q.size(), 0);
    $display("test reset lock done");
    tally_and_finish();
  end
  // Watchdog for a hung run
  initial begin
    #800000;
    num_errors++;
    $display("unexpected at %0t: run timed out", $time);
    tally_and_finish();
  end
endmodule : tb_top
